// file: design/pwmoc_pkg.sv
// Purpose: Shared constants and state types for the counter-array PWM output block
// Assumes: Special-function register bus with page and 8-bit address
// Notes:   Pin indices name the physical port pins the block can drive
package pwmoc_pkg;
  // Register addresses and pages
  localparam logic [7:0] OUTPUT_EN_ADDR  = 8'hF1;
  localparam logic [7:0] AUX_ADDR        = 8'hA4;
  localparam logic [3:0] UPPER_EN_PAGE   = 4'h4;
  localparam logic [3:0] ROUTING_PAGE    = 4'h2;
  // Reset values
  localparam logic [7:0] OUTPUT_EN_RST   = 8'h99;
  localparam logic [3:0] UPPER_EN_RST    = 4'hC;   // Bits 7..4 of the auxiliary register
  localparam logic [7:0] ROUTING_RST     = 8'h00;
  // Field positions in pwm_output_enable
  localparam int MAIN0_BIT   = 0;
  localparam int CLONE0A_BIT = 1;
  localparam int CLONE0B_BIT = 2;
  localparam int MAIN1_BIT   = 3;
  localparam int MAIN2_BIT   = 4;
  localparam int CLONE2A_BIT = 5;
  localparam int CLONE2B_BIT = 6;
  localparam int MAIN3_BIT   = 7;
  // Field positions in upper_output_enable_aux, stored as bits 7..4 shifted down by 4
  localparam int MAIN5_BIT   = 3;
  localparam int MAIN4_BIT   = 2;
  localparam int CLKOUT_BIT  = 1;
  localparam int UPPER_LSB   = 4;
  // Field positions in counter_routing_select
  localparam int CH4_SEL_BIT    = 7;
  localparam int CH2_SEL_BIT    = 6;
  localparam int CLONE2_SEL_BIT = 5;
  localparam int CLONE0_SEL_BIT = 4;
  localparam int ODD_SEL_BIT    = 3;
  localparam int EVEN_SEL_BIT   = 2;
  localparam int EXT_CNT_SEL_BIT = 1;
  localparam int CKO_SEL_BIT    = 0;
  // Physical pin indices
  localparam int PIN_P20 = 0;
  localparam int PIN_P21 = 1;
  localparam int PIN_P22 = 2;
  localparam int PIN_P24 = 3;
  localparam int PIN_P26 = 4;
  localparam int PIN_P30 = 5;
  localparam int PIN_P31 = 6;
  localparam int PIN_P33 = 7;
  localparam int PIN_P34 = 8;
  localparam int PIN_P35 = 9;
  localparam int PIN_P40 = 10;
  localparam int PIN_P41 = 11;
  localparam int PIN_P47 = 12;
  localparam int PIN_P60 = 13;
  localparam int PIN_P61 = 14;
  localparam int PIN_MOD1 = 15;
  localparam int PIN_N   = 16;
  localparam int NMOD    = 6;
  // Resolution codes
  localparam logic [1:0] RES_8  = 2'h0;
  localparam logic [1:0] RES_10 = 2'h1;
  localparam logic [1:0] RES_12 = 2'h2;
  localparam logic [1:0] RES_16 = 2'h3;
  localparam logic [15:0] FULL_COUNT = 16'hFFFF;

  typedef struct packed {
    logic [16:0] act;       // Active extended compare value
    logic        eq_prev;   // Compare equality one cycle ago
  } pwmoc_chan_s;

  typedef struct packed {
    logic [7:0]       out_en;
    logic [3:0]       upper_en;
    logic [7:0]       routing;
    logic [2:0]       pair_q;
    logic [NMOD-1:0]  tog;
    logic             clk_div;
    logic [PIN_N-1:0] drv;
    logic [PIN_N-1:0] oe;
    logic             cap2;
    logic             cap4;
    logic             ext_cnt;
    logic [7:0]       rdata;
  } pwmoc_top_s;
endpackage : pwmoc_pkg

// file: design/pwmoc_channel.sv
// Purpose: One module's resolution-selectable PWM comparator with optional buffering
// Assumes: Counter advances in the cycle that cnt_tick_in is high
// Notes:   Level and match are combinational from the channel state and inputs
`timescale 1ns/100ps
`default_nettype none
module pwmoc_channel (
  input  wire logic        ref_clk_in,
  input  wire logic        nrst_in,
  input  wire logic [15:0] cnt_in,
  input  wire logic        cnt_tick_in,
  input  wire logic [16:0] cmp_in,
  input  wire logic [1:0]  res_in,
  input  wire logic        buffered_in,
  output logic             level_out,
  output logic             match_out
);
  import pwmoc_pkg::*;

  pwmoc_chan_s st_reg;
  pwmoc_chan_s st_next;
  logic [15:0] mask;
  logic [16:0] ext_bit;
  logic [16:0] cnt_m;
  logic [16:0] stage_m;
  logic [16:0] act_use;
  logic        ovf;
  logic        eq;

  // Width mask and extension bit position per resolution code
  always_comb begin
    unique case (res_in)
      RES_8:   begin mask = 16'h00FF; ext_bit = 17'h00100; end
      RES_10:  begin mask = 16'h03FF; ext_bit = 17'h00400; end
      RES_12:  begin mask = 16'h0FFF; ext_bit = 17'h01000; end
      RES_16:  begin mask = 16'hFFFF; ext_bit = 17'h10000; end
    endcase
  end

  // Extended compare and counter values, counter's extension always zero
  assign cnt_m   = {1'b0, cnt_in & mask};
  assign stage_m = {1'b0, cmp_in[15:0] & mask} | (cmp_in[16] ? ext_bit : 17'h00000);
  // Overflow when the selected low bits wrap from all ones
  assign ovf     = cnt_tick_in && ((cnt_in & mask) == mask);
  // Unbuffered uses each written byte at once; buffered uses the held copy
  assign act_use = buffered_in ? st_reg.act : stage_m;
  assign level_out = cnt_m >= act_use;
  assign eq        = cnt_m[15:0] == act_use[15:0];
  // One pulse per arrival at the compare point, selected resolution
  assign match_out = eq && !st_reg.eq_prev;

  // Buffered: reload the held copy only at overflow so a duty change lands whole; unbuffered reloads every cycle
  always_comb begin
    st_next         = st_reg;
    st_next.eq_prev = eq;
    if (!buffered_in || ovf) begin
      st_next.act = stage_m;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  AST_BUF_HOLD: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    buffered_in && !ovf ##1 buffered_in |-> st_reg.act == $past(st_reg.act))
    else $error("buffered compare changed outside overflow");
endmodule : pwmoc_channel
`default_nettype wire

// file: design/pwmoc_output_control.sv
// Purpose: Output gating, inversion, pairing, cloning, clock output and pin routing
// Assumes: Counter, compare bytes and per-module mode bits live outside this block
// Notes:   Pin outputs and read data are registered, one cycle behind their causes
// Notes on behaviour
// - Unbuffered compare uses each byte immediately
// - Buffered variant applies duty change whole
// - Compare-toggle uses selected-resolution match
// - Compare-toggle works at all four resolutions
// - Paired: even starts, odd ends cycle
// - Separate enable per module pair
// - Pins 1,3,4,5 port I/O or PWM
// - Invert bit chooses normal or inverted level
// - Main enable gates pin; resets to one
// - Modules 0,2 have clones, reset disabled
// - Modules 4,5 enables on page four
// - Clock output runs at half overflow rate
// - Module 4 capture from pin or comparator
// - Module 2 capture from pin or oscillator
// - Module 2 clones P4.0/P4.1 or P3.4/P3.5
// - Module 0 clones P2.0/P2.1 or P6.0/P6.1
// - Modules 3,5 at P3.4/P3.5 or P2.0/P2.1
// - Modules 0,2,4 at P2.x or P3.x
// - External count input P1.3 or P1.6
// - Clock output at P4.7 or P3.3
// - Resolution codes give 8/10/12/16 overflow
// - Output low below compare, else high
`timescale 1ns/100ps
`default_nettype none
module pwmoc_output_control (
  input  wire logic                           ref_clk_in,
  input  wire logic                           nrst_in,
  input  wire logic [7:0]                     sfr_addr_in,
  input  wire logic [3:0]                     sfr_page_in,
  input  wire logic                           sfr_wr_in,
  input  wire logic                           sfr_rd_in,
  input  wire logic [7:0]                     sfr_wdata_in,
  input  wire logic [15:0]                    cnt_in,
  input  wire logic                           cnt_tick_in,
  input  wire logic [pwmoc_pkg::NMOD-1:0][16:0] cmp_in,
  input  wire logic [pwmoc_pkg::NMOD-1:0][1:0]  resolution_select_in,
  input  wire logic [pwmoc_pkg::NMOD-1:0]     output_invert_in,
  input  wire logic [pwmoc_pkg::NMOD-1:0]     pwm_mode_in,
  input  wire logic [pwmoc_pkg::NMOD-1:0]     compare_toggle_on_pwm_match_in,
  input  wire logic [pwmoc_pkg::NMOD-1:0]     buffered_in,
  input  wire logic [2:0]                     pair_enable_in,
  input  wire logic [pwmoc_pkg::PIN_N-1:0]    pin_in,
  input  wire logic                           p13_in,
  input  wire logic                           p16_in,
  input  wire logic                           analog_compare_out_in,
  input  wire logic                           low_speed_osc_clock_in,
  output logic [pwmoc_pkg::PIN_N-1:0]         pin_drv_out,
  output logic [pwmoc_pkg::PIN_N-1:0]         pin_oe_out,
  output logic                                cap2_out,
  output logic                                cap4_out,
  output logic                                ext_count_input_out,
  output logic [7:0]                          sfr_rdata_out
);
  import pwmoc_pkg::*;

  pwmoc_top_s      st_reg;
  pwmoc_top_s      st_next;
  logic [NMOD-1:0] level;
  logic [NMOD-1:0] match;
  logic [NMOD-1:0] paired;
  logic [NMOD-1:0] out_lvl;
  logic [NMOD-1:0] main_en;
  logic [NMOD-1:0] main_drive;
  logic            hit_en;
  logic            hit_upper;
  logic            hit_route;
  logic            base_ovf;

  // Per-module comparators; a pair always runs buffered
  genvar gi;
  generate
    for (gi = 0; gi < NMOD; gi++) begin : g_chan
      assign paired[gi] = pair_enable_in[gi / 2];
      pwmoc_channel u_chan (
        .ref_clk_in  (ref_clk_in),
        .nrst_in     (nrst_in),
        .cnt_in      (cnt_in),
        .cnt_tick_in (cnt_tick_in),
        .cmp_in      (cmp_in[gi]),
        .res_in      (resolution_select_in[gi]),
        .buffered_in (buffered_in[gi] | paired[gi]),
        .level_out   (level[gi]),
        .match_out   (match[gi])
      );
    end
  endgenerate

  // Register decode; the shared address is split by page
  assign hit_en    = sfr_addr_in == OUTPUT_EN_ADDR;
  assign hit_upper = (sfr_addr_in == AUX_ADDR) && (sfr_page_in == UPPER_EN_PAGE);
  assign hit_route = (sfr_addr_in == AUX_ADDR) && (sfr_page_in == ROUTING_PAGE);
  // Base counter overflow for the divided clock output
  assign base_ovf  = cnt_tick_in && (cnt_in == FULL_COUNT);

  // Main enables gathered across the two registers
  assign main_en = {st_reg.upper_en[MAIN5_BIT], st_reg.upper_en[MAIN4_BIT],
                    st_reg.out_en[MAIN3_BIT], st_reg.out_en[MAIN2_BIT],
                    st_reg.out_en[MAIN1_BIT], st_reg.out_en[MAIN0_BIT]};

  // Module output level before pin routing
  generate
    for (gi = 0; gi < NMOD; gi++) begin : g_lvl
      logic raw;
      // Even pair member in compare-toggle mode shows the shared set/clear flop
      assign raw = !compare_toggle_on_pwm_match_in[gi] ? level[gi] :
                   ((gi % 2 == 0) && paired[gi]) ? st_reg.pair_q[gi / 2] : st_reg.tog[gi];
      assign out_lvl[gi] = raw ^ output_invert_in[gi];
      // Odd pair member hands its pin back to port I/O
      assign main_drive[gi] = pwm_mode_in[gi] && main_en[gi] && !((gi % 2 == 1) && paired[gi]);
    end
  endgenerate

  // Next-state logic for registers, toggles, routing and inputs
  always_comb begin
    st_next = st_reg;
    st_next.rdata = 8'h00;
    st_next.drv   = '0;
    st_next.oe    = '0;

    // Register writes; low nibble of the upper register is write-only and not kept
    if (sfr_wr_in && hit_en) begin
      st_next.out_en = sfr_wdata_in;
    end
    if (sfr_wr_in && hit_upper) begin
      st_next.upper_en = sfr_wdata_in[7:UPPER_LSB];
    end
    if (sfr_wr_in && hit_route) begin
      st_next.routing = sfr_wdata_in;
    end

    // Read data; unmapped addresses answer zero
    if (sfr_rd_in) begin
      if (hit_en) begin
        st_next.rdata = st_reg.out_en;
      end else if (hit_upper) begin
        st_next.rdata = {st_reg.upper_en, 4'h0};
      end else if (hit_route) begin
        st_next.rdata = st_reg.routing;
      end
    end

    // Unpaired compare-toggle: flip on each match of the chosen width
    for (int i = 0; i < NMOD; i++) begin
      if (compare_toggle_on_pwm_match_in[i] && match[i]) begin
        st_next.tog[i] = !st_reg.tog[i];
      end
    end

    // Paired: odd match clears, even match sets; set wins if both land together
    for (int p = 0; p < 3; p++) begin
      if (!pair_enable_in[p]) begin
        st_next.pair_q[p] = 1'b0;
      end else if (match[2 * p]) begin
        st_next.pair_q[p] = 1'b1;
      end else if (match[2 * p + 1]) begin
        st_next.pair_q[p] = 1'b0;
      end
    end

    // Divided clock toggles on every base overflow, so half that rate
    if (!st_reg.upper_en[CLKOUT_BIT]) begin
      st_next.clk_div = 1'b0;
    end else if (base_ovf) begin
      st_next.clk_div = !st_reg.clk_div;
    end

    // Lowest priority first: clock out, then clones, then the main pins
    if (st_reg.upper_en[CLKOUT_BIT]) begin
      if (st_reg.routing[CKO_SEL_BIT]) begin
        st_next.drv[PIN_P33] = st_reg.clk_div;
        st_next.oe[PIN_P33]  = 1'b1;
      end else begin
        st_next.drv[PIN_P47] = st_reg.clk_div;
        st_next.oe[PIN_P47]  = 1'b1;
      end
    end

    // Module 0 clones, each with its own enable
    if (st_reg.out_en[CLONE0A_BIT] && pwm_mode_in[0]) begin
      if (st_reg.routing[CLONE0_SEL_BIT]) begin
        st_next.drv[PIN_P60] = out_lvl[0];
        st_next.oe[PIN_P60]  = 1'b1;
      end else begin
        st_next.drv[PIN_P20] = out_lvl[0];
        st_next.oe[PIN_P20]  = 1'b1;
      end
    end
    if (st_reg.out_en[CLONE0B_BIT] && pwm_mode_in[0]) begin
      if (st_reg.routing[CLONE0_SEL_BIT]) begin
        st_next.drv[PIN_P61] = out_lvl[0];
        st_next.oe[PIN_P61]  = 1'b1;
      end else begin
        st_next.drv[PIN_P21] = out_lvl[0];
        st_next.oe[PIN_P21]  = 1'b1;
      end
    end

    // Module 2 clones
    if (st_reg.out_en[CLONE2A_BIT] && pwm_mode_in[2]) begin
      if (st_reg.routing[CLONE2_SEL_BIT]) begin
        st_next.drv[PIN_P34] = out_lvl[2];
        st_next.oe[PIN_P34]  = 1'b1;
      end else begin
        st_next.drv[PIN_P40] = out_lvl[2];
        st_next.oe[PIN_P40]  = 1'b1;
      end
    end
    if (st_reg.out_en[CLONE2B_BIT] && pwm_mode_in[2]) begin
      if (st_reg.routing[CLONE2_SEL_BIT]) begin
        st_next.drv[PIN_P35] = out_lvl[2];
        st_next.oe[PIN_P35]  = 1'b1;
      end else begin
        st_next.drv[PIN_P41] = out_lvl[2];
        st_next.oe[PIN_P41]  = 1'b1;
      end
    end

    // Main pins of the even modules
    if (main_drive[0]) begin
      st_next.drv[st_reg.routing[EVEN_SEL_BIT] ? PIN_P30 : PIN_P22] = out_lvl[0];
      st_next.oe[st_reg.routing[EVEN_SEL_BIT] ? PIN_P30 : PIN_P22]  = 1'b1;
    end
    if (main_drive[2]) begin
      st_next.drv[st_reg.routing[EVEN_SEL_BIT] ? PIN_P31 : PIN_P24] = out_lvl[2];
      st_next.oe[st_reg.routing[EVEN_SEL_BIT] ? PIN_P31 : PIN_P24]  = 1'b1;
    end
    if (main_drive[4]) begin
      st_next.drv[st_reg.routing[EVEN_SEL_BIT] ? PIN_P33 : PIN_P26] = out_lvl[4];
      st_next.oe[st_reg.routing[EVEN_SEL_BIT] ? PIN_P33 : PIN_P26]  = 1'b1;
    end
    // Main pins of the odd modules; module 1 has a fixed pin
    if (main_drive[1]) begin
      st_next.drv[PIN_MOD1] = out_lvl[1];
      st_next.oe[PIN_MOD1]  = 1'b1;
    end
    if (main_drive[3]) begin
      st_next.drv[st_reg.routing[ODD_SEL_BIT] ? PIN_P20 : PIN_P34] = out_lvl[3];
      st_next.oe[st_reg.routing[ODD_SEL_BIT] ? PIN_P20 : PIN_P34]  = 1'b1;
    end
    if (main_drive[5]) begin
      st_next.drv[st_reg.routing[ODD_SEL_BIT] ? PIN_P21 : PIN_P35] = out_lvl[5];
      st_next.oe[st_reg.routing[ODD_SEL_BIT] ? PIN_P21 : PIN_P35]  = 1'b1;
    end

    // Input sources; capture pins follow the even-group pin selection, the count input has its own select bit
    st_next.cap4 = st_reg.routing[CH4_SEL_BIT] ? analog_compare_out_in :
                   pin_in[st_reg.routing[EVEN_SEL_BIT] ? PIN_P33 : PIN_P26];
    st_next.cap2 = st_reg.routing[CH2_SEL_BIT] ? low_speed_osc_clock_in :
                   pin_in[st_reg.routing[EVEN_SEL_BIT] ? PIN_P31 : PIN_P24];
    st_next.ext_cnt = st_reg.routing[EXT_CNT_SEL_BIT] ? p16_in : p13_in;
  end

  // State register; enables take their documented reset values
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg          <= '0;
      st_reg.out_en   <= OUTPUT_EN_RST;
      st_reg.upper_en <= UPPER_EN_RST;
      st_reg.routing  <= ROUTING_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Every output straight from the state register
  assign pin_drv_out         = st_reg.drv;
  assign pin_oe_out          = st_reg.oe;
  assign cap2_out            = st_reg.cap2;
  assign cap4_out            = st_reg.cap4;
  assign ext_count_input_out = st_reg.ext_cnt;
  assign sfr_rdata_out       = st_reg.rdata;

  AST_MAIN0_GATE: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    !st_reg.out_en[MAIN0_BIT] && !st_reg.routing[EVEN_SEL_BIT] |=> !pin_oe_out[PIN_P22])
    else $error("module 0 pin driven while disabled");
  AST_INVERT: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    main_drive[0] && !st_reg.routing[EVEN_SEL_BIT] && !compare_toggle_on_pwm_match_in[0]
    |=> pin_drv_out[PIN_P22] == $past(level[0] ^ output_invert_in[0]))
    else $error("module 0 pin level wrong");
  AST_CLKOUT_OFF: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    !st_reg.upper_en[CLKOUT_BIT] || st_reg.routing[CKO_SEL_BIT] |=> !pin_oe_out[PIN_P47])
    else $error("clock output on P4.7 unexpectedly");
  AST_CLK_TOGGLE: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    st_reg.upper_en[CLKOUT_BIT] && base_ovf ##1 st_reg.upper_en[CLKOUT_BIT]
    |-> st_reg.clk_div != $past(st_reg.clk_div))
    else $error("divided clock missed an overflow");
  AST_CLONE0_SEL: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    st_reg.out_en[CLONE0A_BIT] && pwm_mode_in[0] && st_reg.routing[CLONE0_SEL_BIT]
    |=> pin_oe_out[PIN_P60])
    else $error("module 0 clone A not on P6.0");
  AST_CLONE2_SEL: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    st_reg.out_en[CLONE2A_BIT] && pwm_mode_in[2] && !st_reg.routing[CLONE2_SEL_BIT]
    |=> pin_oe_out[PIN_P40] && pin_drv_out[PIN_P40] == $past(out_lvl[2]))
    else $error("module 2 clone A not on P4.0");
  AST_CAP4_SRC: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    st_reg.routing[CH4_SEL_BIT] |=> cap4_out == $past(analog_compare_out_in))
    else $error("module 4 capture source wrong");
  AST_CAP2_SRC: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    st_reg.routing[CH2_SEL_BIT] |=> cap2_out == $past(low_speed_osc_clock_in))
    else $error("module 2 capture source wrong");
  AST_EXT_CNT_SEL: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    !st_reg.routing[EXT_CNT_SEL_BIT] |=> ext_count_input_out == $past(p13_in))
    else $error("count input not from P1.3");
  AST_PAIR_SET: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    pair_enable_in[0] && match[0] |=> st_reg.pair_q[0])
    else $error("even match did not set pair output");
  AST_PAIR_CLR: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    pair_enable_in[0] && match[1] && !match[0] |=> !st_reg.pair_q[0])
    else $error("odd match did not clear pair output");
endmodule : pwmoc_output_control
`default_nettype wire

// file: dv/pwmoc_pin_model.sv
// Purpose: Far-side model: base counter feeding the block and board-level pin resolution
// Assumes: Counter advances once per clock; undriven pins take the board level
// Notes:   Counter moves by non-blocking update on the rising edge, so the bench load is never raced
`timescale 1ns/100ps
`default_nettype none
module pwmoc_pin_model (
  input  wire logic                        ref_clk_in,
  input  wire logic                        nrst_in,
  input  wire logic                        cnt_load_in,
  input  wire logic [pwmoc_pkg::PIN_N-1:0] ext_lvl_in,
  input  wire logic [pwmoc_pkg::PIN_N-1:0] pin_drv_in,
  input  wire logic [pwmoc_pkg::PIN_N-1:0] pin_oe_in,
  output logic      [15:0]                 cnt_out,
  output logic                             cnt_tick_out,
  output logic      [pwmoc_pkg::PIN_N-1:0] pin_lvl_out
);
  import pwmoc_pkg::*;
  // Load jumps close to the wrap so an overflow comes without a 64k-cycle wait
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_out <= 16'h0000;
    end else if (cnt_load_in) begin
      cnt_out <= 16'hFFF0;
    end else begin
      cnt_out <= cnt_out + 16'h0001;
    end
  end
  assign cnt_tick_out = nrst_in; // Every cycle advances the counter
  // A pin the block releases shows the board level, never its last driven value
  assign pin_lvl_out = (pin_oe_in & pin_drv_in) | (~pin_oe_in & ext_lvl_in);
endmodule : pwmoc_pin_model
`default_nettype wire

// file: dv/pwmoc_output_control_tb.sv
// Purpose: Self-checking bench for output gating, routing, clock output and registers
// Assumes: Register writes act at the taken edge; pins follow one edge later
// Notes:   Compare 0 gives a steady high level, bit 16 set gives steady low at 8 bits
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module pwmoc_output_control_tb;
  import pwmoc_pkg::*;
  logic                  ref_clk_in = 1'b0, nrst_in = 1'b0, wr = 1'b0, rd = 1'b0, ld = 1'b0;
  logic                  p13 = 1'b0, p16 = 1'b0, acmp = 1'b0, osc = 1'b0, tick, cap2, cap4, ext_cnt;
  logic [7:0]            addr = 8'h00, wdata = 8'h00, rdata;
  logic [3:0]            page = 4'h0;
  logic [15:0]           cnt;
  logic [NMOD-1:0][16:0] cmp = '0;
  logic [NMOD-1:0][1:0]  res = '0;
  logic [NMOD-1:0]       inv = '0, mode = '0, tog = '0, bsel = '0;
  logic [2:0]            pair = 3'h0;
  logic [PIN_N-1:0]      ext = '1, lvl, drv, oe;
  int                    n_errors = 0, n_compared = 0;

  pwmoc_output_control DUT (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .sfr_addr_in(addr),
    .sfr_page_in(page), .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(wdata), .cnt_in(cnt),
    .cnt_tick_in(tick), .cmp_in(cmp), .resolution_select_in(res), .output_invert_in(inv),
    .pwm_mode_in(mode), .compare_toggle_on_pwm_match_in(tog), .buffered_in(bsel),
    .pair_enable_in(pair), .pin_in(lvl), .p13_in(p13), .p16_in(p16), .analog_compare_out_in(acmp),
    .low_speed_osc_clock_in(osc), .pin_drv_out(drv), .pin_oe_out(oe), .cap2_out(cap2),
    .cap4_out(cap4), .ext_count_input_out(ext_cnt), .sfr_rdata_out(rdata));
  pwmoc_pin_model partner (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .cnt_load_in(ld),
    .ext_lvl_in(ext), .pin_drv_in(drv), .pin_oe_in(oe), .cnt_out(cnt), .cnt_tick_out(tick),
    .pin_lvl_out(lvl));

  always #5 ref_clk_in = ~ref_clk_in;

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask : cyc
  // One register access; read data is judged in the cycle after the taken edge
  task automatic acc(input logic w, input logic [3:0] pg, input logic [7:0] a, input logic [7:0] d,
                     input logic [7:0] e);
    wr = w;
    rd = !w;
    page = pg;
    addr = a;
    wdata = d;
    cyc(1);
    wr = 1'b0;
    rd = 1'b0;
    if (!w) `CHK(rdata, e)
    cyc(1);
  endtask : acc
  // Jumps the counter near its wrap, then counts flips of one pin over the next 20 cycles
  task automatic wrap_flips(input int idx, output int flips);
    logic prev;
    flips = 0;
    ld = 1'b1;
    cyc(1);
    ld = 1'b0;
    cyc(1);
    prev = drv[idx];
    repeat (20) begin
      cyc(1);
      if (drv[idx] !== prev) flips++;
      prev = drv[idx];
    end
  endtask : wrap_flips

  task automatic t_regs;
    acc(1'b0, 4'h0, OUTPUT_EN_ADDR, 8'h00, 8'h99);
    acc(1'b0, UPPER_EN_PAGE, AUX_ADDR, 8'h00, 8'hC0);
    acc(1'b0, ROUTING_PAGE, AUX_ADDR, 8'h00, 8'h00);
    acc(1'b0, 4'h0, 8'h10, 8'h00, 8'h00); // Unmapped place reads zero
    acc(1'b1, 4'h7, OUTPUT_EN_ADDR, 8'h66, 8'h00);
    acc(1'b0, 4'h3, OUTPUT_EN_ADDR, 8'h00, 8'h66);
    acc(1'b1, UPPER_EN_PAGE, AUX_ADDR, 8'h2F, 8'h00);
    acc(1'b0, UPPER_EN_PAGE, AUX_ADDR, 8'h00, 8'h20);
    acc(1'b1, UPPER_EN_PAGE, AUX_ADDR, 8'hC0, 8'h00);
    acc(1'b1, 4'h0, OUTPUT_EN_ADDR, 8'h99, 8'h00);
  endtask : t_regs

  task automatic t_pwm;
    mode[1:0] = 2'b11;
    cyc(3);
    `CHK({oe[PIN_P22], drv[PIN_P22], oe[PIN_MOD1]}, 3'b111)
    inv[0] = 1'b1;
    cyc(2);
    `CHK(lvl[PIN_P22], 1'b0)
    inv[0] = 1'b0;
    cmp[0] = 17'h10000;
    cyc(2);
    `CHK(drv[PIN_P22], 1'b0)
    pair[0] = 1'b1;
    cyc(2);
    `CHK(oe[PIN_MOD1], 1'b0)
    pair = 3'h0;
    cmp[0] = 17'h00000;
    acc(1'b1, 4'h0, OUTPUT_EN_ADDR, 8'h98, 8'h00);
    `CHK(oe[PIN_P22], 1'b0)
    acc(1'b1, 4'h0, OUTPUT_EN_ADDR, 8'h9F, 8'h00);
    acc(1'b1, ROUTING_PAGE, AUX_ADDR, 8'h14, 8'h00);
    `CHK({oe[PIN_P30], oe[PIN_P22], oe[PIN_P60], oe[PIN_P61], lvl[PIN_P60]}, 5'b10111)
    acc(1'b1, ROUTING_PAGE, AUX_ADDR, 8'h00, 8'h00);
    mode = '0;
  endtask : t_pwm

  // Clock output flips once per base overflow, so one flip across the wrap
  task automatic t_clk;
    int flips;
    acc(1'b1, UPPER_EN_PAGE, AUX_ADDR, 8'hE0, 8'h00);
    `CHK(oe[PIN_P47], 1'b1)
    wrap_flips(PIN_P47, flips);
    `CHK(flips, 1)
    acc(1'b1, ROUTING_PAGE, AUX_ADDR, 8'h01, 8'h00);
    `CHK({oe[PIN_P33], oe[PIN_P47]}, 2'b10)
    acc(1'b1, UPPER_EN_PAGE, AUX_ADDR, 8'hC0, 8'h00);
    `CHK(oe[PIN_P33], 1'b0)
  endtask : t_clk

  task automatic t_in;
    ext[PIN_P26] = 1'b0;
    ext[PIN_P24] = 1'b0;
    {acmp, osc, p16} = 3'b111;
    cyc(2);
    `CHK({cap4, cap2, ext_cnt}, 3'b000)
    acc(1'b1, ROUTING_PAGE, AUX_ADDR, 8'hC2, 8'h00);
    `CHK({cap4, cap2, ext_cnt}, 3'b111)
    {acmp, osc, p16} = 3'b000;
    cyc(2);
    `CHK({cap4, cap2, ext_cnt}, 3'b000)
  endtask : t_in

  // Compare-toggle at every width, paired set/clear, then a buffered duty change
  task automatic t_tog;
    int n;
    mode[0] = 1'b1;
    tog[0] = 1'b1;
    cmp[0] = 17'h0FFF8;
    for (int r = 0; r < 4; r++) begin
      res[0] = r[1:0];
      wrap_flips(PIN_P22, n);
      `CHK(n, 1)
    end
    // Low byte only: a fixed 16-bit compare would never meet it near the wrap
    cmp[0] = 17'h000F8;
    wrap_flips(PIN_P22, n);
    `CHK(n, 0)
    res[0] = RES_8;
    wrap_flips(PIN_P22, n);
    `CHK(n, 1)
    // Compares are set one cycle before pairing so the held copies take them
    res = '0;
    cmp[0] = 17'h000F4;
    cmp[1] = 17'h000FA;
    mode[1:0] = 2'b11;
    tog[1:0] = 2'b11;
    cyc(1);
    pair[0] = 1'b1;
    wrap_flips(PIN_P22, n);
    `CHK(n, 2)
    `CHK({oe[PIN_MOD1], drv[PIN_P22]}, 2'b00)
    pair = 3'h0;
    tog = '0;
    cmp[0] = 17'h00000;
    cyc(1);
    bsel[0] = 1'b1;
    ld = 1'b1;
    cyc(1);
    ld = 1'b0;
    cmp[0] = 17'h10000;
    cyc(4);
    `CHK(drv[PIN_P22], 1'b1)
    cyc(20);
    `CHK(drv[PIN_P22], 1'b0)
    bsel = '0;
    mode = '0;
  endtask : t_tog

  task automatic close_out;
    if (n_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  // Tests need a few hundred cycles; the limit leaves ample room
  initial begin
    #100000;
    n_errors++;
    close_out();
  end
  initial begin
    cyc(12);
    nrst_in = 1'b1;
    cyc(1);
    t_regs();
    t_pwm();
    t_clk();
    t_in();
    t_tog();
    close_out();
  end
endmodule : pwmoc_output_control_tb
`default_nettype wire
